// ### bmc_cfg.svh
// timing, mode and size constants of the buffer memory controller
`ifndef BMC_CFG_SVH
`define BMC_CFG_SVH
`define BMC_CLK_HZ          20000000
`define BMC_REFRESH_NS      15600
`define BMC_REFRESH_CYC     ((`BMC_REFRESH_NS * (`BMC_CLK_HZ / 1000000)) / 1000)
`define BMC_SEG_MIN_SHIFT   8
`define BMC_SRAM_AW         18
`define BMC_DRAM_AW         20
`define BMC_FIFO_DEPTH      16
`define BMC_FIFO_WIDTH      31
`define BMC_PWR_BIT_A       3
`define BMC_PWR_BIT_B       4
`endif

// ### bmc_pkg.sv
// types shared by the buffer memory controller files
package bmc_pkg;
  typedef enum logic [1:0] {
    BMC_REQ_HOST = 2'h0,
    BMC_REQ_DISK = 2'h1,
    BMC_REQ_MPU  = 2'h2,
    BMC_REQ_REF  = 2'h3
  } bmc_req_t;

  // gray along idle -> row -> col -> done -> idle
  typedef enum logic [2:0] {
    BMC_ST_IDLE = 3'h0,
    BMC_ST_ROW  = 3'h1,
    BMC_ST_COL  = 3'h3,
    BMC_ST_DONE = 3'h2,
    BMC_ST_SRAM = 3'h6
  } bmc_state_t;
endpackage

// ### bmc_fifo.sv
// parameterised synchronous FIFO with registered read data
`timescale 1ns/1ps
module bmc_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             system_clock_in,
  input  wire logic             reset,
  // write side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // read side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             outValid_q;
  logic [WIDTH-1:0] outData_q;
  logic             empty;
  logic             full;
  logic             pop;

  assign empty    = (wrPtr_q == rdPtr_q);
  assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) &&
                    (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign inReady  = !full;
  // output register refills when empty or being drained
  assign pop      = !empty && (!outValid_q || outReady);
  assign outValid = outValid_q;
  assign outData  = outData_q;

  always_ff @(posedge system_clock_in) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
    if (pop) begin
      outData_q <= mem[rdPtr_q[AW-1:0]];
    end
    if (reset) begin
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      outValid_q <= 1'b0;
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q    <= rdPtr_q + 1'b1;
        outValid_q <= 1'b1;
      end else if (outReady) begin
        outValid_q <= 1'b0;
      end
    end
  end
endmodule

// ### bmc_ctrl.sv
// buffer memory controller: arbiter, pointers and RAM cycle engine
// What this block does
// - drive sixteen buffer address outputs
// - pin one: address 16 or row strobe
// - pin two: address 17 or column strobe
// - eight-bit bidirectional data bus to RAM
// - output enable: DRAM reads, any SRAM access
// - pulse low write enable to store data
// - address and strobes synchronous to clock
// - power-down stops clock, starts no access
// - memory select low during SRAM access
// - memory select high when idle
// - both power bits set inhibit clocks
// - arbitrate host, disk, mpu, refresh requests
// - address 256 kB SRAM or 1 MB DRAM
// - segments of 256 bytes or more
// - separate host, disk and mpu pointers
// - interleaved address generation
// - one byte per three (SRAM) or four (DRAM) cycles
`timescale 1ns/1ps
`include "bmc_cfg.svh"
module bmc_ctrl
  import bmc_pkg::*;
#(
  parameter int REFRESH_CYC = `BMC_REFRESH_CYC
) (
  // clock and reset
  input  wire logic        system_clock_in,
  input  wire logic        reset,
  // configuration
  input  wire logic        dramMode,
  input  wire logic [7:0]  clockControl,
  input  wire logic [11:0] segSize,
  input  wire logic [1:0]  interleaveShift,
  // host port requests
  input  wire logic        hostReq,
  input  wire logic        hostWrite,
  input  wire logic [7:0]  hostWrData,
  input  wire logic        hostLoad,
  input  wire logic [19:0] hostLoadAddr,
  output logic             hostReady,
  // disk port requests
  input  wire logic        diskReq,
  input  wire logic        diskWrite,
  input  wire logic [7:0]  diskWrData,
  input  wire logic        diskLoad,
  input  wire logic [19:0] diskLoadAddr,
  output logic             diskReady,
  // microprocessor port requests
  input  wire logic        mpuReq,
  input  wire logic        mpuWrite,
  input  wire logic [7:0]  mpuWrData,
  input  wire logic        mpuLoad,
  input  wire logic [19:0] mpuLoadAddr,
  output logic             mpuReady,
  // read data return
  output logic             rdValid,
  output logic [1:0]       rdPort,
  output logic [7:0]       rdData,
  // buffer RAM pins
  output logic [15:0]      buffer_addr_lines,
  output logic             addr16RowStrobe,
  output logic             addr17ColStrobe,
  input  wire logic [7:0]  bufferDataIn,
  output logic [7:0]       bufferDataOut,
  output logic             bufferDataOe,
  output logic             memory_output_enable_n,
  output logic             writeEnable_n,
  output logic             buffer_chip_select_n,
  // status
  output logic             powerDown
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    bmc_state_t  st;
    logic [19:0] hostPtr;
    logic [19:0] diskPtr;
    logic [19:0] mpuPtr;
    logic [19:0] refRow;
    logic [15:0] refCnt;
    logic        refPend;
    logic        curWrite;
    logic [1:0]  curPort;
    logic [19:0] curAddr;
    logic [7:0]  curData;
    logic [15:0] addrOut;
    logic        a16Ras;
    logic        a17Cas;
    logic        oe;
    logic        we;
    logic        cs;
    logic        drive;
    logic [7:0]  dOut;
    logic        rdValid;
    logic [7:0]  rdData;
    logic [1:0]  rdPort;
    logic [7:0]  din1;
    logic [7:0]  din2;
    logic        ret1;
    logic        ret2;
    logic [1:0]  ret1Port;
    logic [1:0]  ret2Port;
  } bmc_regs_t;

  bmc_regs_t s_q;
  bmc_regs_t s_d;

  logic             fifoInValid;
  logic             fifoInReady;
  logic [30:0]      fifoInData;
  logic             fifoOutValid;
  logic             fifoOutReady;
  logic [30:0]      fifoOutData;
  bmc_req_t         winner;
  logic             anyReq;
  logic [19:0]      winAddr;
  logic             winWrite;
  logic [7:0]       winData;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // pointer advance: interleave stride, wrap inside segment
  function automatic logic [19:0] nextPtr(input logic [19:0] p,
                                          input logic [11:0] seg,
                                          input logic [1:0]  sh);
    logic [19:0] segBytes;
    logic [19:0] base;
    logic [19:0] off;
    segBytes = {seg, 8'h00};
    base     = (segBytes == 20'h00000) ? 20'h00000 :
               (p - (p % segBytes));
    off      = p - base + (20'h00001 << sh);
    if (segBytes != 20'h00000 && off >= segBytes) begin
      off = off - segBytes + 20'h00001;
    end
    nextPtr = base + off;
  endfunction

  // clamp address to the size the RAM type can reach
  function automatic logic [19:0] clampAddr(input logic [19:0] a,
                                            input logic        dram);
    clampAddr = dram ? a : {2'h0, a[17:0]};
  endfunction

  // ---------------------------------------------------------------
  // arbitration: refresh, disk, host, mpu in fixed priority
  // ---------------------------------------------------------------
  assign powerDown = clockControl[`BMC_PWR_BIT_A] &&
                     clockControl[`BMC_PWR_BIT_B];

  always_comb begin
    anyReq   = !powerDown && fifoInReady;
    winner   = BMC_REQ_MPU;
    winAddr  = s_q.mpuPtr;
    winWrite = mpuWrite;
    winData  = mpuWrData;
    if (dramMode && s_q.refPend) begin
      winner   = BMC_REQ_REF;
      winAddr  = s_q.refRow;
      winWrite = 1'b0;
      winData  = 8'h00;
    end else if (diskReq) begin
      winner   = BMC_REQ_DISK;
      winAddr  = s_q.diskPtr;
      winWrite = diskWrite;
      winData  = diskWrData;
    end else if (hostReq) begin
      winner   = BMC_REQ_HOST;
      winAddr  = s_q.hostPtr;
      winWrite = hostWrite;
      winData  = hostWrData;
    end else if (!mpuReq) begin
      anyReq = 1'b0;
    end
  end

  assign fifoInValid = anyReq;
  assign fifoInData  = {winner, winWrite, winData,
                        clampAddr(winAddr, dramMode)};
  assign hostReady   = anyReq && winner == BMC_REQ_HOST;
  assign diskReady   = anyReq && winner == BMC_REQ_DISK;
  assign mpuReady    = anyReq && winner == BMC_REQ_MPU;

  bmc_fifo #(
    .WIDTH (`BMC_FIFO_WIDTH),
    .DEPTH (`BMC_FIFO_DEPTH)
  ) u_fifo (
    .system_clock_in   (system_clock_in),
    .reset    (reset),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // engine takes a queued access only while idle and powered
  assign fifoOutReady = (s_q.st == BMC_ST_IDLE) && !powerDown;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.rdValid = 1'b0;
    s_d.din1    = bufferDataIn;
    s_d.din2    = s_q.din1;

    // read tag trails the bus by the depth of the input flops
    s_d.ret1     = 1'b0;
    s_d.ret2     = s_q.ret1;
    s_d.ret2Port = s_q.ret1Port;
    if (s_q.ret2) begin
      s_d.rdValid = 1'b1;
      s_d.rdPort  = s_q.ret2Port;
      s_d.rdData  = s_q.din2;
    end

    // refresh timer; pending flag set wins over its own clear
    if (s_q.refCnt >= 16'(REFRESH_CYC - 1)) begin
      s_d.refCnt  = 16'h0000;
      s_d.refPend = 1'b1;
    end else begin
      s_d.refCnt = s_q.refCnt + 16'h0001;
    end

    // pointers advance or reload per port
    if (hostLoad) begin
      s_d.hostPtr = hostLoadAddr;
    end else if (hostReady) begin
      s_d.hostPtr = nextPtr(s_q.hostPtr, segSize, interleaveShift);
    end
    if (diskLoad) begin
      s_d.diskPtr = diskLoadAddr;
    end else if (diskReady) begin
      s_d.diskPtr = nextPtr(s_q.diskPtr, segSize, interleaveShift);
    end
    if (mpuLoad) begin
      s_d.mpuPtr = mpuLoadAddr;
    end else if (mpuReady) begin
      s_d.mpuPtr = nextPtr(s_q.mpuPtr, segSize, interleaveShift);
    end
    if (anyReq && winner == BMC_REQ_REF) begin
      s_d.refRow = s_q.refRow + 20'h00400;
      if (s_d.refCnt != 16'h0000) begin
        s_d.refPend = 1'b0;
      end
    end

    unique case (s_q.st)
      BMC_ST_IDLE: begin
        s_d.oe    = 1'b0;
        s_d.we    = 1'b0;
        s_d.cs    = 1'b0;
        s_d.drive = 1'b0;
        s_d.a16Ras = dramMode ? 1'b1 : 1'b0;
        s_d.a17Cas = dramMode ? 1'b1 : 1'b0;
        if (fifoOutValid && fifoOutReady) begin
          s_d.curPort  = fifoOutData[30:29];
          s_d.curWrite = fifoOutData[28];
          s_d.curData  = fifoOutData[27:20];
          s_d.curAddr  = fifoOutData[19:0];
          s_d.dOut     = fifoOutData[27:20];
          if (dramMode) begin
            // row half first, strobes still high
            s_d.addrOut = {6'h00, fifoOutData[19:10]};
            s_d.st      = BMC_ST_ROW;
          end else begin
            s_d.addrOut = fifoOutData[15:0];
            s_d.a16Ras  = fifoOutData[16];
            s_d.a17Cas  = fifoOutData[17];
            s_d.cs      = 1'b1;
            s_d.oe      = 1'b1;
            s_d.we      = fifoOutData[28];
            s_d.drive   = fifoOutData[28];
            s_d.st      = BMC_ST_SRAM;
          end
        end
      end
      BMC_ST_SRAM: begin
        s_d.we = 1'b0;
        s_d.st = BMC_ST_DONE;
      end
      BMC_ST_ROW: begin
        s_d.a16Ras = 1'b0;
        s_d.st     = BMC_ST_COL;
      end
      BMC_ST_COL: begin
        s_d.addrOut = {6'h00, s_q.curAddr[9:0]};
        s_d.a17Cas  = (s_q.curPort == BMC_REQ_REF);
        s_d.oe      = !s_q.curWrite && s_q.curPort != BMC_REQ_REF;
        s_d.we      = s_q.curWrite;
        s_d.drive   = s_q.curWrite;
        s_d.st      = BMC_ST_DONE;
      end
      BMC_ST_DONE: begin
        if (!s_q.curWrite && s_q.curPort != BMC_REQ_REF) begin
          // bus sampled at this edge, strobes still active
          s_d.ret1     = 1'b1;
          s_d.ret1Port = s_q.curPort;
        end
        s_d.we     = 1'b0;
        s_d.oe     = 1'b0;
        s_d.cs     = 1'b0;
        s_d.drive  = 1'b0;
        s_d.a16Ras = dramMode;
        s_d.a17Cas = dramMode;
        s_d.st     = BMC_ST_IDLE;
      end
      default: begin
        s_d.st = BMC_ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers; power-down freezes all state once the engine is idle and no read tag is in flight
  // ---------------------------------------------------------------
  always_ff @(posedge system_clock_in) begin
    if (reset) begin
      s_q        <= '0;
      s_q.st     <= BMC_ST_IDLE;
      s_q.a16Ras <= 1'b1;
      s_q.a17Cas <= 1'b1;
    end else if (!powerDown || s_q.st != BMC_ST_IDLE ||
                 s_q.ret1 || s_q.ret2) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign buffer_addr_lines      = s_q.addrOut;
  assign addr16RowStrobe        = s_q.a16Ras;
  assign addr17ColStrobe        = s_q.a17Cas;
  assign bufferDataOut          = s_q.dOut;
  assign bufferDataOe           = s_q.drive;
  assign memory_output_enable_n = !s_q.oe;
  assign writeEnable_n          = !s_q.we;
  assign buffer_chip_select_n   = !s_q.cs;
  assign rdValid                = s_q.rdValid;
  assign rdPort                 = s_q.rdPort;
  assign rdData                 = s_q.rdData;
endmodule

// ### bmc_ctrl_assertions.sv
// pin-level checker of the buffer memory controller
`timescale 1ns/1ps
module bmc_ctrl_checker #(
  parameter int REFRESH_CYC = 312
) (
  // clock and reset
  input wire logic        system_clock_in,
  input wire logic        reset,
  // configuration and requests
  input wire logic        dramMode,
  input wire logic        hostReq,
  input wire logic        hostReady,
  input wire logic        diskReq,
  input wire logic        diskReady,
  input wire logic        mpuReq,
  input wire logic        mpuReady,
  input wire logic        powerDown,
  input wire logic        rdValid,
  // buffer RAM pins
  input wire logic [15:0] buffer_addr_lines,
  input wire logic        addr16RowStrobe,
  input wire logic        addr17ColStrobe,
  input wire logic        bufferDataOe,
  input wire logic        memory_output_enable_n,
  input wire logic        writeEnable_n,
  input wire logic        buffer_chip_select_n
);
  default clocking @(posedge system_clock_in); endclocking
  default disable iff (reset);
  // cycles since the row strobe last went low, DRAM and awake only
  int unsigned gapQ;
  always_ff @(posedge system_clock_in) begin
    if (reset || !addr16RowStrobe || !dramMode || powerDown) begin
      gapQ <= 32'h0;
    end else begin
      gapQ <= gapQ + 32'h1;
    end
  end
  a_row_addr_first: assert property (dramMode && $fell(addr16RowStrobe)
    |-> $stable(buffer_addr_lines)) else $error("row address moved");
  a_col_in_row: assert property (dramMode && !addr17ColStrobe
    |-> !addr16RowStrobe) else $error("column strobe outside row");
  a_we_drives_bus: assert property (!writeEnable_n |-> bufferDataOe)
    else $error("write without driving the bus");
  a_no_bus_fight: assert property (dramMode && !memory_output_enable_n
    |-> !bufferDataOe) else $error("bus driven while RAM reads");
  a_sram_oe_cs: assert property (!dramMode && !buffer_chip_select_n
    |-> !memory_output_enable_n) else $error("oe off during access");
  a_cs_brief: assert property ($fell(buffer_chip_select_n)
    |-> ##[1:6] buffer_chip_select_n) else $error("select held");
  a_we_pulse: assert property ($fell(writeEnable_n)
    |-> ##[1:3] writeEnable_n) else $error("write enable stuck");
  a_pd_no_grant: assert property (powerDown
    |-> !hostReady && !diskReady && !mpuReady) else $error("pd grant");
  a_pd_no_access: assert property (powerDown && buffer_chip_select_n
    |=> buffer_chip_select_n) else $error("access in power-down");
  a_one_grant: assert property ($onehot0({hostReq && hostReady,
    diskReq && diskReady, mpuReq && mpuReady})) else $error("two grants");
  a_disk_first: assert property (hostReq && hostReady |-> !diskReq)
    else $error("host granted over disk");
  a_refresh_gap: assert property (gapQ <= 4 * REFRESH_CYC)
    else $error("refresh overdue");
  c_read: cover property (rdValid);
  c_dram_write: cover property (dramMode && !writeEnable_n);
  c_dram_row: cover property (dramMode && $fell(addr16RowStrobe));
endmodule

bind bmc_ctrl bmc_ctrl_checker #(.REFRESH_CYC(REFRESH_CYC)) u_checker (
  .system_clock_in(system_clock_in), .reset(reset), .dramMode(dramMode),
  .hostReq(hostReq), .hostReady(hostReady), .diskReq(diskReq),
  .diskReady(diskReady), .mpuReq(mpuReq), .mpuReady(mpuReady),
  .powerDown(powerDown), .rdValid(rdValid),
  .buffer_addr_lines(buffer_addr_lines),
  .addr16RowStrobe(addr16RowStrobe), .addr17ColStrobe(addr17ColStrobe),
  .bufferDataOe(bufferDataOe),
  .memory_output_enable_n(memory_output_enable_n),
  .writeEnable_n(writeEnable_n),
  .buffer_chip_select_n(buffer_chip_select_n));

// ### bmc_ram_model.sv
// behavioural static or dynamic byte-wide buffer RAM
`timescale 1ns/1ps
module bmc_ram_model (
  // clock and mode
  input wire logic        system_clock_in,
  input wire logic        dramMode,
  // address and strobes
  input wire logic [15:0] addrLines,
  input wire logic        pinA16,
  input wire logic        pinA17,
  input wire logic        oeN,
  input wire logic        weN,
  input wire logic        csN,
  // data bus halves
  input wire logic [7:0]  dataOut,
  output logic [7:0]      dataIn
);
  logic [7:0]  mem [logic [31:0]];
  logic [15:0] rowQ;
  logic [15:0] colQ;
  logic [31:0] key;
  logic [7:0]  lastQ;
  logic        sel;
  always @(negedge pinA16) if (dramMode) rowQ = addrLines;
  always @(negedge pinA17) if (dramMode) colQ = addrLines;
  assign key = dramMode ? {rowQ, colQ} : {14'h0, pinA17, pinA16, addrLines};
  assign sel = dramMode ? !pinA17 : !csN;
  always @(posedge system_clock_in) begin
    if (!weN && sel) mem[key] = dataOut;
    if (!oeN && sel && weN) lastQ = dataIn;
  end
  // released bus shows the inverse so stale data cannot pass
  always @* begin
    if (!oeN && sel && weN) begin
      dataIn = mem.exists(key) ? mem[key] : 8'h5A;
    end else begin
      dataIn = ~lastQ;
    end
  end
endmodule

// ### bmc_ctrl_bench.sv
// self-checking bench of the buffer memory controller
`timescale 1ns/1ps
module bmc_ctrl_bench;
  logic        system_clock_in, reset, dramMode, a16, a17, dOe, oeN, weN, csN, pd;
  logic        rdValid;
  logic [1:0]  rdPort, shift;
  logic [11:0] seg;
  logic [7:0]  clockControl, rdData, dIn, dOut;
  logic [15:0] addrLines;
  logic        req [3], wr [3], ld [3], rdy [3];
  logic [7:0]  wd [3];
  logic [19:0] la [3], ptr [3];
  logic [7:0]  refMem [logic [19:0]];
  logic [9:0]  expQ [$];
  logic [9:0]  e;
  int          mismatches, cmp_count, refusals, rasFalls;
  bmc_ctrl #(.REFRESH_CYC(20)) DUT (
    .system_clock_in(system_clock_in), .reset(reset), .dramMode(dramMode),
    .clockControl(clockControl), .segSize(seg),
    .interleaveShift(shift),
    .hostReq(req[0]), .hostWrite(wr[0]), .hostWrData(wd[0]),
    .hostLoad(ld[0]), .hostLoadAddr(la[0]), .hostReady(rdy[0]),
    .diskReq(req[1]), .diskWrite(wr[1]), .diskWrData(wd[1]),
    .diskLoad(ld[1]), .diskLoadAddr(la[1]), .diskReady(rdy[1]),
    .mpuReq(req[2]), .mpuWrite(wr[2]), .mpuWrData(wd[2]),
    .mpuLoad(ld[2]), .mpuLoadAddr(la[2]), .mpuReady(rdy[2]),
    .rdValid(rdValid), .rdPort(rdPort), .rdData(rdData),
    .buffer_addr_lines(addrLines), .addr16RowStrobe(a16),
    .addr17ColStrobe(a17), .bufferDataIn(dIn), .bufferDataOut(dOut),
    .bufferDataOe(dOe), .memory_output_enable_n(oeN),
    .writeEnable_n(weN), .buffer_chip_select_n(csN), .powerDown(pd));
  bmc_ram_model RAM (.system_clock_in(system_clock_in), .dramMode(dramMode),
    .addrLines(addrLines), .pinA16(a16), .pinA17(a17), .oeN(oeN),
    .weN(weN), .csN(csN), .dataOut(dOut), .dataIn(dIn));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // pointer model: stride steps, a wrap lands on the next lane
  function automatic logic [19:0] step(input logic [19:0] a,
      input logic [11:0] sg, input logic [1:0] sh);
    logic [19:0] sb, off;
    sb  = {sg, 8'h00};
    off = a % sb + (20'h1 << sh);
    if (off >= sb) off = off - sb + 20'h1;
    return a - a % sb + off;
  endfunction
  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic load(input int p, input logic [19:0] a);
    @(negedge system_clock_in);
    ld[p] = 1'b1;
    la[p] = a;
    ptr[p] = a;
    @(negedge system_clock_in);
    ld[p] = 1'b0;
  endtask
  // request held high across back-to-back transfers
  task automatic run(input int p, input int n, input logic w);
    logic got;
    @(negedge system_clock_in);
    req[p] = 1'b1;
    for (int i = 0; i < n; i++) begin
      wr[p] = w;
      wd[p] = 8'($urandom);
      got = 1'b0;
      for (int t = 0; t < 300 && !got; t++) begin
        #24 got = rdy[p];
        if (!got) refusals++;
        @(negedge system_clock_in);
      end
      check(got, "grant timeout");
      if (w) refMem[ptr[p]] = wd[p];
      else expQ.push_back({2'(p), refMem[ptr[p]]});
      ptr[p] = step(ptr[p], seg, shift);
    end
    req[p] = 1'b0;
  endtask
  task automatic do_reset(input logic m);
    @(negedge system_clock_in);
    reset = 1'b1;
    dramMode = m;
    repeat (8) @(negedge system_clock_in);
    reset = 1'b0;
    refusals = 0;
  endtask
  // ----------------------------------------------------------------
  // clock, read monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    system_clock_in = 1'b0;
    forever #25 system_clock_in = ~system_clock_in;
  end
  always @(negedge a16) if (dramMode) rasFalls++;
  always @(negedge system_clock_in) begin
    if (!reset && rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        check(1'b0, "unexpected read data");
      end else begin
        e = expQ.pop_front();
        check(rdPort === e[9:8] && rdData === e[7:0], "read data");
      end
    end
  end
  initial begin
    #(50 * 40000);
    mismatches++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    dramMode = 1'b0;
    clockControl = 8'h00;
    shift = 2'h0;
    seg = 12'h001;
    for (int p = 0; p < 3; p++) begin
      req[p] = 1'b0;
      wr[p] = 1'b0;
      ld[p] = 1'b0;
      wd[p] = 8'h00;
      la[p] = 20'h00000;
    end
    void'($urandom(32'h6C0A046A));
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      shift = 2'($urandom_range(3));
      // host pointer starts near a segment end so it must wrap
      seg = m[0] ? 12'h001 : 12'h002;
      load(0, 20'h3FFF0);
      run(0, 30, 1'b1);
      if (m == 0) check(refusals > 0, "fifo never refused");
      load(1, 20'h1A000);
      load(2, m[0] ? 20'hC4000 : 20'h04000);
      fork
        run(1, 12, 1'b1);
        run(2, 12, 1'b1);
      join
      load(0, 20'h3FFF0);
      load(1, 20'h1A000);
      load(2, m[0] ? 20'hC4000 : 20'h04000);
      fork
        run(0, 30, 1'b0);
        run(1, 12, 1'b0);
        run(2, 12, 1'b0);
      join
      for (int t = 0; t < 600 && expQ.size() > 0; t++) @(negedge system_clock_in);
      check(expQ.size() == 0, "reads missing");
      rasFalls = 0;
      repeat (60) @(negedge system_clock_in);
      if (m == 1) check(rasFalls >= 2, "no refresh");
      for (int c = 0; c < 4; c++) begin
        @(negedge system_clock_in);
        clockControl = 8'(c << 3);
        #1 check(pd === (c == 3), "power-down decode");
      end
      req[0] = 1'b1;
      repeat (10) begin
        @(negedge system_clock_in);
        check(rdy[0] === 1'b0 && csN === 1'b1, "access while down");
      end
      req[0] = 1'b0;
      @(negedge system_clock_in);
      clockControl = 8'h00;
    end
    end_sim();
  end
endmodule
